/* File: src/uft_defs.vh */
// constants for the usb frame timing and done-queue block
`ifndef UFT_DEFS_VH
`define UFT_DEFS_VH
// apb byte addresses
`define UFT_ADDR_DONE_HEAD    32'h90101030
`define UFT_ADDR_FM_INTERVAL  32'h90101034
`define UFT_ADDR_FM_REMAINING 32'h90101038
`define UFT_ADDR_CONTROL      32'h90101100
`define UFT_ADDR_INT_STATUS   32'h90101104
`define UFT_ADDR_INT_ENABLE   32'h90101108
`define UFT_ADDR_INT_CLEAR    32'h9010110C
`define UFT_ADDR_AREA_BASE    32'h90101110
// field positions
`define UFT_FIT_BIT     31
`define UFT_LARGEST_PACKET_BUDGET_MSB   30
`define UFT_LARGEST_PACKET_BUDGET_LSB   16
`define UFT_FI_MSB      13
`define UFT_FI_LSB      0
`define UFT_FRT_BIT     31
`define UFT_DH_MSB      31
`define UFT_DH_LSB      4
`define UFT_AREA_LSB    8
`define UFT_CTRL_RUN    0
`define UFT_CTRL_RESET  1
`define UFT_INT_WDH     0
`define UFT_INT_SOF     1
`define UFT_INT_WIDTH   2
// reset values
`define UFT_FI_NOMINAL  14'h2EDF
`define UFT_LARGEST_PACKET_BUDGET_RESET 15'h0000
// memory layout offsets
`define UFT_LINK_OFS    32'h00000008
`define UFT_AREA_DH_OFS 32'h00000084
// bit-time rate: clock and full-speed bit rate in mhz
`define UFT_CLK_MHZ     7'd50
`define UFT_BIT_MHZ     7'd12
`endif

/* File: src/uft_bit_tick.v */
// fractional divider producing one pulse per full-speed bit time
`timescale 1ns/10ps
`include "uft_defs.vh"
module uft_bit_tick (
  input  wire pclk,
  input  wire presetn,
  output reg  bit_tick
);
  reg  [6:0] acc;
  wire [6:0] sum = acc + `UFT_BIT_MHZ;

  // phase accumulator: 12 ticks per 50 clocks, jitter of one clock is harmless here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc      <= 7'h00;
      bit_tick <= 1'b0;
    end else if (sum >= `UFT_CLK_MHZ) begin
      acc      <= sum - `UFT_CLK_MHZ;
      bit_tick <= 1'b1;
    end else begin
      acc      <= sum;
      bit_tick <= 1'b0;
    end
  end
endmodule // uft_bit_tick

/* File: src/uft_frame_timer.v */
// remaining-bit-time down counter, toggle copy and frame number
`timescale 1ns/10ps
`include "uft_defs.vh"
module uft_frame_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        soft_clear,
  input  wire        run,
  input  wire        bit_tick,
  input  wire [13:0] interval,
  input  wire        interval_toggle,
  output reg  [13:0] remaining_bit_time,
  output reg         remaining_toggle,
  output reg  [15:0] frame_number_count,
  output reg         frame_start
);
  // counter advances only on bit-time boundaries while running
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining_bit_time <= 14'h0000;
      remaining_toggle   <= 1'b0;
      frame_number_count <= 16'h0000;
      frame_start        <= 1'b0;
    end else if (soft_clear) begin
      remaining_bit_time <= 14'h0000;
      remaining_toggle   <= 1'b0;
      frame_number_count <= 16'h0000;
      frame_start        <= 1'b0;
    end else begin
      frame_start <= 1'b0;
      if (run && bit_tick) begin
        if (remaining_bit_time == 14'h0000) begin
          remaining_bit_time <= interval;
          frame_number_count <= frame_number_count + 16'h0001;
          frame_start        <= 1'b1;
        end else begin
          remaining_bit_time <= remaining_bit_time - 14'h0001;
          if (remaining_bit_time == 14'h0001)
            remaining_toggle <= interval_toggle;
        end
      end
    end
  end
endmodule // uft_frame_timer

/* File: src/uft_frame_done_queue.v */
// usb host frame timing and done-queue head logic with apb registers
//
// Overview of operation
// - link completed descriptor to current head
// - head becomes completed descriptor address
// - head clears on write to shared area
// - head write-back sets sticky status flag
// - head in bits 31:4, read-only, low zero
// - packet budget counter loads each frame start
// - interval field resets to nominal 11999
// - controller reset restores nominal interval
// - remaining toggle copied when counter hits zero
// - remaining counter decrements each bit time
// - zero counter reloads interval next bit time
// - each reload increments wrapping frame number
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`include "uft_defs.vh"
module uft_frame_done_queue (
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // completed descriptor offer from list processing
  input  wire        td_done_valid,
  input  wire [31:0] td_done_addr,
  output reg         td_done_ready,
  // request to write the head out to the shared area
  input  wire        writeback_request,
  // memory write master
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  // packet budget use: one bit moved per strobe
  input  wire        budget_bit_used,
  output reg  [14:0] largest_packet_count,
  // frame timing and interrupt outputs
  output wire        frame_start,
  output wire [15:0] frame_number_count,
  output reg         irq
);
  localparam S_IDLE  = 2'd0;
  localparam S_LINK  = 2'd1;
  localparam S_WBACK = 2'd2;

  reg  [1:0]  state;
  reg  [27:0] done_queue_head_addr;
  reg  [27:0] pending_td;
  reg         interval_toggle;
  reg  [14:0] largest_packet_budget;
  reg  [13:0] frame_interval;
  reg  [23:0] area_base;
  reg         frame_run;
  reg         soft_clear;
  reg  [`UFT_INT_WIDTH-1:0] int_status;
  reg  [`UFT_INT_WIDTH-1:0] int_enable;
  reg         wb_pending;
  reg  [31:0] next_rdata;
  reg         next_slverr;
  wire        bit_tick;
  wire [13:0] remaining_bit_time;
  wire        remaining_toggle;
  wire        apb_setup_end;
  wire        apb_done;
  wire        wr_en;
  wire        wb_take;
  wire        td_take;
  wire        link_done;
  wire        wback_done;
  wire [`UFT_INT_WIDTH-1:0] int_set;
  wire [`UFT_INT_WIDTH-1:0] int_clr;

  // bit-time pulse source
  uft_bit_tick u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .bit_tick (bit_tick)
  );

  // frame counter, toggle and frame number
  uft_frame_timer u_timer (
    .pclk               (pclk),
    .presetn            (presetn),
    .soft_clear         (soft_clear),
    .run                (frame_run),
    .bit_tick           (bit_tick),
    .interval           (frame_interval),
    .interval_toggle    (interval_toggle),
    .remaining_bit_time (remaining_bit_time),
    .remaining_toggle   (remaining_toggle),
    .frame_number_count (frame_number_count),
    .frame_start        (frame_start)
  );

  // apb phases: one wait state, write commits at the pready edge
  assign apb_setup_end = psel & penable & ~pready;
  assign apb_done      = psel & penable & pready;
  assign wr_en         = apb_done & pwrite;

  // done-queue sequencer handshakes
  assign wb_take    = (state == S_IDLE) & ~soft_clear & wb_pending;
  assign td_take    = (state == S_IDLE) & ~soft_clear & ~wb_pending & td_done_valid;
  assign link_done  = (state == S_LINK) & mem_ack;
  assign wback_done = (state == S_WBACK) & mem_ack;

  // interrupt events and software clear
  assign int_set = {frame_start, wback_done};
  assign int_clr = (wr_en && paddr == `UFT_ADDR_INT_CLEAR) ?
                   pwdata[`UFT_INT_WIDTH-1:0] : {`UFT_INT_WIDTH{1'b0}};

  // read mux and error answer for unmapped addresses
  always @* begin
    next_rdata  = 32'h00000000;
    next_slverr = 1'b0;
    if (paddr == `UFT_ADDR_DONE_HEAD) begin
      next_rdata[`UFT_DH_MSB:`UFT_DH_LSB] = done_queue_head_addr;
    end else if (paddr == `UFT_ADDR_FM_INTERVAL) begin
      next_rdata[`UFT_FIT_BIT]                 = interval_toggle;
      next_rdata[`UFT_LARGEST_PACKET_BUDGET_MSB:`UFT_LARGEST_PACKET_BUDGET_LSB] = largest_packet_budget;
      next_rdata[`UFT_FI_MSB:`UFT_FI_LSB]       = frame_interval;
    end else if (paddr == `UFT_ADDR_FM_REMAINING) begin
      next_rdata[`UFT_FRT_BIT]           = remaining_toggle;
      next_rdata[`UFT_FI_MSB:`UFT_FI_LSB] = remaining_bit_time;
    end else if (paddr == `UFT_ADDR_CONTROL) begin
      next_rdata[`UFT_CTRL_RUN] = frame_run;
    end else if (paddr == `UFT_ADDR_INT_STATUS) begin
      next_rdata[`UFT_INT_WIDTH-1:0] = int_status;
    end else if (paddr == `UFT_ADDR_INT_ENABLE) begin
      next_rdata[`UFT_INT_WIDTH-1:0] = int_enable;
    end else if (paddr == `UFT_ADDR_INT_CLEAR) begin
      next_rdata = 32'h00000000; // write-only, reads zero
    end else if (paddr == `UFT_ADDR_AREA_BASE) begin
      next_rdata[31:`UFT_AREA_LSB] = area_base;
    end else begin
      next_slverr = 1'b1;
    end
  end

  // apb answer flops: data and error stand only in the pready cycle, zero otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup_end;
      if (apb_setup_end) begin
        prdata  <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_slverr;
      end else begin
        // an error left standing past pready would look like a second answer
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // control: run bit and self-clearing controller reset request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_run  <= 1'b0;
      soft_clear <= 1'b0;
    end else begin
      soft_clear <= 1'b0;
      if (soft_clear) begin
        frame_run <= 1'b0;
      end else if (wr_en && paddr == `UFT_ADDR_CONTROL) begin
        frame_run  <= pwdata[`UFT_CTRL_RUN];
        soft_clear <= pwdata[`UFT_CTRL_RESET];
      end
    end
  end

  // frame interval register; software keeps the toggle discipline itself
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_toggle       <= 1'b0;
      largest_packet_budget <= `UFT_LARGEST_PACKET_BUDGET_RESET;
      frame_interval        <= `UFT_FI_NOMINAL;
    end else if (soft_clear) begin
      interval_toggle       <= 1'b0;
      largest_packet_budget <= `UFT_LARGEST_PACKET_BUDGET_RESET;
      frame_interval        <= `UFT_FI_NOMINAL;
    end else if (wr_en && paddr == `UFT_ADDR_FM_INTERVAL) begin
      // a rewrite mid-frame only takes hold at the next reload
      interval_toggle       <= pwdata[`UFT_FIT_BIT];
      largest_packet_budget <= pwdata[`UFT_LARGEST_PACKET_BUDGET_MSB:`UFT_LARGEST_PACKET_BUDGET_LSB];
      frame_interval        <= pwdata[`UFT_FI_MSB:`UFT_FI_LSB];
    end
  end

  // shared area base, 256-byte aligned
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area_base <= 24'h000000;
    end else if (soft_clear) begin
      area_base <= 24'h000000;
    end else if (wr_en && paddr == `UFT_ADDR_AREA_BASE) begin
      area_base <= pwdata[31:`UFT_AREA_LSB];
    end
  end

  // largest-data-packet counter: loaded each frame, counts bits down
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      largest_packet_count <= 15'h0000;
    end else if (soft_clear) begin
      largest_packet_count <= 15'h0000;
    end else if (frame_start) begin
      largest_packet_count <= largest_packet_budget;
    end else if (budget_bit_used && largest_packet_count != 15'h0000) begin
      largest_packet_count <= largest_packet_count - 15'h0001;
    end
  end

  // write-back request is remembered until the sequencer takes it; a new one wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_pending <= 1'b0;
    end else if (soft_clear) begin
      wb_pending <= 1'b0;
    end else if (writeback_request) begin
      wb_pending <= 1'b1;
    end else if (wb_take) begin
      wb_pending <= 1'b0;
    end
  end

  // done-queue sequencer: write-back has priority so the area never goes stale
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                <= S_IDLE;
      done_queue_head_addr <= 28'h0000000;
      pending_td           <= 28'h0000000;
      mem_req              <= 1'b0;
      mem_addr             <= 32'h00000000;
      mem_wdata            <= 32'h00000000;
      td_done_ready        <= 1'b0;
    end else if (soft_clear) begin
      state                <= S_IDLE;
      done_queue_head_addr <= 28'h0000000;
      mem_req              <= 1'b0;
      td_done_ready        <= 1'b0;
    end else begin
      td_done_ready <= 1'b0;
      case (state)
        S_IDLE: begin
          if (wb_take) begin
            state     <= S_WBACK;
            mem_req   <= 1'b1;
            mem_addr  <= {area_base, 8'h00} + `UFT_AREA_DH_OFS;
            mem_wdata <= {done_queue_head_addr, 4'h0};
          end else if (td_take) begin
            state         <= S_LINK;
            pending_td    <= td_done_addr[31:4];
            td_done_ready <= 1'b1;
            mem_req       <= 1'b1;
            mem_addr      <= {td_done_addr[31:4], 4'h0} + `UFT_LINK_OFS;
            mem_wdata     <= {done_queue_head_addr, 4'h0};
          end
        end
        S_LINK: begin
          if (link_done) begin
            mem_req              <= 1'b0;
            done_queue_head_addr <= pending_td;
            state                <= S_IDLE;
          end
        end
        S_WBACK: begin
          if (wback_done) begin
            mem_req              <= 1'b0;
            done_queue_head_addr <= 28'h0000000;
            state                <= S_IDLE;
          end
        end
        default: begin
          state   <= S_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  // sticky status: an event in the clearing cycle survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= {`UFT_INT_WIDTH{1'b0}};
    end else if (soft_clear) begin
      int_status <= {`UFT_INT_WIDTH{1'b0}};
    end else begin
      int_status <= (int_status & ~int_clr) | int_set;
    end
  end

  // interrupt enable register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable <= {`UFT_INT_WIDTH{1'b0}};
    end else if (soft_clear) begin
      int_enable <= {`UFT_INT_WIDTH{1'b0}};
    end else if (wr_en && paddr == `UFT_ADDR_INT_ENABLE) begin
      int_enable <= pwdata[`UFT_INT_WIDTH-1:0];
    end
  end

  // level interrupt, registered so it lags status by one clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable);
    end
  end
endmodule // uft_frame_done_queue

/* File: sim/uft_frame_done_queue_checker.sv */
// assertion checker for the frame timing and done-queue block
`timescale 1ns/10ps
`include "uft_defs.vh"
module uft_frame_done_queue_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] td_done_addr,
  input wire        td_done_ready,
  input wire        mem_req,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire        mem_ack,
  input wire        frame_start,
  input wire [15:0] frame_number_count
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answers after exactly one wait state, for one cycle
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // descriptor link write goes to the link field of the taken descriptor
  a_link_addr: assert property (td_done_ready |-> mem_req && mem_addr == $past(td_done_addr) + `UFT_LINK_OFS)
    else $error("link write address wrong");
  // memory request must not wobble while memory is slow
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_head_low: assert property (pready && !pwrite && paddr == `UFT_ADDR_DONE_HEAD |-> prdata[3:0] == 4'h0)
    else $error("done head low bits not zero");
  a_rem_rsv: assert property (pready && !pwrite && paddr == `UFT_ADDR_FM_REMAINING |-> prdata[30:14] == 17'h0)
    else $error("remaining reserved bits not zero");
  // a tick is at least four clocks, so strobes never come closer
  a_sof_single: assert property (frame_start |=> !frame_start [*3])
    else $error("frame strobe too long or too close");
  a_fn_step: assert property ($changed(frame_number_count) |-> frame_number_count == $past(frame_number_count) + 16'h1 || frame_number_count == 16'h0)
    else $error("frame number jumped");
endmodule // uft_frame_done_queue_checker

bind uft_frame_done_queue uft_frame_done_queue_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .td_done_addr, .td_done_ready, .mem_req,
  .mem_addr, .mem_wdata, .mem_ack, .frame_start, .frame_number_count);

/* File: sim/uft_mem_model.sv */
// system memory model taking single-word writes with a set latency
`timescale 1ns/10ps
module uft_mem_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [3:0]  lat,
  input  wire        mem_req,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  output reg         mem_ack,
  output reg  [31:0] last_addr,
  output reg  [31:0] last_data
);
  reg [3:0] cnt;
  // ack only once per request; the write lands at the ack edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      last_addr <= 32'h0;
      last_data <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && mem_ack) begin
        last_addr <= mem_addr;
        last_data <= mem_wdata;
      end else if (mem_req) begin
        if (cnt == lat) begin
          mem_ack <= 1'b1;
          cnt     <= 4'h0;
        end else cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // uft_mem_model

/* File: sim/uft_frame_done_queue_bench.sv */
// self-checking bench for the frame timing and done-queue block
`timescale 1ns/10ps
`include "uft_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module uft_frame_done_queue_bench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [31:0] paddr = 0, pwdata = 0, td_done_addr = 0, rd, sv;
  reg         td_done_valid = 0, writeback_request = 0, budget_bit_used = 0, er;
  reg  [3:0]  lat = 0;
  wire [31:0] prdata, mem_addr, mem_wdata, last_addr, last_data;
  wire [15:0] fn;
  wire [14:0] lpc;
  wire        pready, pslverr, td_done_ready, mem_req, mem_ack, frame_start, irq;
  int         n_fail = 0, samples_checked = 0, waited;
  reg  [15:0] fn0;

  uft_frame_done_queue u_uft_frame_done_queue (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .td_done_valid(td_done_valid),
    .td_done_addr(td_done_addr), .td_done_ready(td_done_ready),
    .writeback_request(writeback_request), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .budget_bit_used(budget_bit_used),
    .largest_packet_count(lpc), .frame_start(frame_start), .frame_number_count(fn), .irq(irq));
  uft_mem_model u_uft_mem_model (.pclk(pclk), .presetn(presetn), .lat(lat), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .last_addr(last_addr),
    .last_data(last_data));

  // 50 mhz clock
  initial forever #10 pclk = ~pclk;

  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for a design signal to reach a level: 0 ready, 1 mem_req, 2 frame strobe
  task wait_for(input int sel, input logic lvl);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge pclk);
      waited++;
      if ((sel == 0 ? td_done_ready : sel == 1 ? mem_req : frame_start) === lvl) return;
    end
    n_fail++;
    final_report();
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input [31:0] a, input [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin n_fail++; final_report(); end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // offer one completed descriptor and wait for its link write to finish
  task offer(input [31:0] a);
    @(posedge pclk);
    td_done_valid <= 1; td_done_addr <= a;
    wait_for(0, 1'b1);
    td_done_valid <= 0;
    wait_for(1, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    // reset values, read-only head, unmapped place
    apb(0, `UFT_ADDR_DONE_HEAD, 0);    `CHK(rd, 32'h0)
    apb(0, `UFT_ADDR_FM_INTERVAL, 0);  `CHK(rd, 32'h00002EDF)
    apb(0, `UFT_ADDR_FM_REMAINING, 0); `CHK(rd, 32'h0)
    apb(0, 32'h90101200, 0);           `CHK({er, rd}, {1'b1, 32'h0})
    apb(1, `UFT_ADDR_DONE_HEAD, 32'h12345670);
    apb(0, `UFT_ADDR_DONE_HEAD, 0);    `CHK(rd, 32'h0)
    // short frame of 20 bit times, toggle flipped, budget 0x10
    apb(1, `UFT_ADDR_FM_INTERVAL, 32'h80100013);
    apb(0, `UFT_ADDR_FM_INTERVAL, 0);  `CHK(rd, 32'h80100013)
    apb(1, `UFT_ADDR_INT_ENABLE, 32'h1);
    apb(1, `UFT_ADDR_AREA_BASE, 32'h00040000);
    apb(1, `UFT_ADDR_CONTROL, 32'h1);
    wait_for(2, 1'b1);
    wait_for(2, 1'b1);
    fn0 = fn;
    waited = 0;
    repeat (12) wait_for(2, 1'b1);
    // twelve frames of 20 ticks at 12 ticks per 50 clocks: 1000 clocks
    `CHK(waited >= 995 && waited <= 1005, 1'b1)
    `CHK(fn, fn0 + 16'd12)
    repeat (2) @(posedge pclk);
    `CHK(lpc, 15'h0010)
    budget_bit_used <= 1;
    repeat (3) @(posedge pclk);
    budget_bit_used <= 0;
    @(posedge pclk);
    `CHK(lpc, 15'h000D)
    apb(0, `UFT_ADDR_FM_REMAINING, 0);
    `CHK({rd[31], rd[13:0] <= 14'd19}, 2'b11)
    // retrim with toggle back to zero
    apb(1, `UFT_ADDR_FM_INTERVAL, 32'h00100013);
    repeat (3) wait_for(2, 1'b1);
    apb(0, `UFT_ADDR_FM_REMAINING, 0); `CHK(rd[31], 1'b0)
    // two descriptors, prompt then slow memory
    offer(32'h00002000);
    `CHK({last_addr, last_data}, {32'h00002008, 32'h0})
    apb(0, `UFT_ADDR_DONE_HEAD, 0);    `CHK(rd, 32'h00002000)
    lat <= 4'h5;
    offer(32'h00003000);
    `CHK({last_addr, last_data}, {32'h00003008, 32'h00002000})
    apb(0, `UFT_ADDR_DONE_HEAD, 0);    `CHK(rd, 32'h00003000)
    // head written out to the shared area
    @(posedge pclk);
    writeback_request <= 1;
    @(posedge pclk);
    writeback_request <= 0;
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    `CHK({last_addr, last_data}, {32'h00040084, 32'h00003000})
    apb(0, `UFT_ADDR_DONE_HEAD, 0);    `CHK(rd, 32'h0)
    apb(0, `UFT_ADDR_INT_STATUS, 0);   `CHK(rd[1:0], 2'b11)
    `CHK(irq, 1'b1)
    apb(1, `UFT_ADDR_INT_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1, `UFT_ADDR_INT_CLEAR, 32'h1);
    apb(0, `UFT_ADDR_INT_STATUS, 0);   `CHK(rd[0], 1'b0)
    // controller reset with interval saved and restored
    apb(1, `UFT_ADDR_FM_INTERVAL, 32'h00002EA0);
    apb(0, `UFT_ADDR_FM_INTERVAL, 0);
    sv = rd;
    apb(1, `UFT_ADDR_CONTROL, 32'h2);
    apb(0, `UFT_ADDR_FM_INTERVAL, 0);  `CHK(rd, 32'h00002EDF)
    apb(1, `UFT_ADDR_FM_INTERVAL, sv);
    apb(0, `UFT_ADDR_FM_INTERVAL, 0);  `CHK(rd, 32'h00002EA0)
    final_report();
  end
endmodule // uft_frame_done_queue_bench
